// file: core/mdu_pkg.sv
/*
 * Shared constants for the multiply/divide unit and the integer execution core around it.
 * Assumes a single 40 MHz pipeline clock and a synchronous active-high reset.
 */
package mdu_pkg;
    // ==========================================================
    // Widths
    localparam int DATA_W   = 32;
    localparam int REG_CNT  = 32;
    localparam int IDX_W    = 5;
    localparam int OP_W     = 5;
    localparam int CLK_MHZ  = 40;

    // ==========================================================
    // Operation codes; bit 4 marks work for the multiply/divide unit
    localparam logic [4:0] OP_NOP      = 5'h00;
    localparam logic [4:0] OP_AND      = 5'h01;
    localparam logic [4:0] OP_OR       = 5'h02;
    localparam logic [4:0] OP_XOR      = 5'h03;
    localparam logic [4:0] OP_ADD      = 5'h04;
    localparam logic [4:0] OP_SUB      = 5'h05;
    localparam logic [4:0] OP_SLL      = 5'h06;
    localparam logic [4:0] OP_SRL      = 5'h07;
    localparam logic [4:0] OP_SRA      = 5'h08;
    localparam logic [4:0] OP_CLZ      = 5'h09;
    localparam logic [4:0] OP_CLO      = 5'h0A;
    localparam logic [4:0] OP_LOAD_IMM = 5'h0B;
    localparam logic [4:0] OP_MULT     = 5'h10;
    localparam logic [4:0] OP_MULTU    = 5'h11;
    localparam logic [4:0] OP_MADD     = 5'h12;
    localparam logic [4:0] OP_MADDU    = 5'h13;
    localparam logic [4:0] OP_MSUB     = 5'h14;
    localparam logic [4:0] OP_MSUBU    = 5'h15;
    localparam logic [4:0] OP_MUL      = 5'h16;
    localparam logic [4:0] OP_DIV      = 5'h18;
    localparam logic [4:0] OP_DIVU     = 5'h19;
    localparam logic [4:0] OP_MFHI     = 5'h1E;
    localparam logic [4:0] OP_MFLO     = 5'h1F;
    localparam int         OP_MDU_BIT  = 4;

    // ==========================================================
    // Divider timing in pipeline clocks
    localparam int DIV_ITER_FULL = 32;
    localparam int DIV_SKIP_8    = 23;
    localparam int DIV_SKIP_16   = 15;
    localparam int DIV_SKIP_24   = 7;
    localparam int DIV_LAT_8     = 12;
    localparam int DIV_LAT_16    = 19;
    localparam int DIV_LAT_24    = 26;
    localparam int DIV_LAT_32    = 33;

    // ==========================================================
    // State encodings
    typedef enum logic [1:0] {
        MUL_IDLE  = 2'b01,
        MUL_PASS2 = 2'b10
    } mdu_mul_e;

    typedef enum logic [2:0] {
        DIV_IDLE = 3'b001,
        DIV_PAD  = 3'b010,
        DIV_ITER = 3'b100
    } mdu_div_e;
endpackage

// file: core/mdu_divider.sv
/*
 * Iterative restoring divider, one quotient bit per clock, with early-in skipping.
 * Assumes start is a one-cycle pulse given only while busy is low or last is high.
 */
module mdu_divider
    import mdu_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              start,
    input  wire logic              is_signed,
    input  wire logic [DATA_W-1:0] dividend,
    input  wire logic [DATA_W-1:0] divisor,
    output logic                   busy,
    output logic                   last,
    output logic [DATA_W-1:0]      quotient,
    output logic [DATA_W-1:0]      remainder
);
    // ==========================================================
    // Early-in plan: {pad cycles, iterations}
    function automatic logic [11:0] div_plan(input logic [31:0] a, input logic sg);
        logic [11:0] p;
        p = {6'(DIV_LAT_32 - 1 - DIV_ITER_FULL), 6'(DIV_ITER_FULL)};
        if (sg ? (&a[31:23] | ~|a[31:23]) : ~|a[31:24])
            p = {6'(DIV_LAT_24 - 1 - (DIV_ITER_FULL - DIV_SKIP_24)),
                 6'(DIV_ITER_FULL - DIV_SKIP_24)};
        if (sg ? (&a[31:15] | ~|a[31:15]) : ~|a[31:16])
            p = {6'(DIV_LAT_16 - 1 - (DIV_ITER_FULL - DIV_SKIP_16)),
                 6'(DIV_ITER_FULL - DIV_SKIP_16)};
        if (sg ? (&a[31:7] | ~|a[31:7]) : ~|a[31:8])
            p = {6'(DIV_LAT_8 - 1 - (DIV_ITER_FULL - DIV_SKIP_8)),
                 6'(DIV_ITER_FULL - DIV_SKIP_8)};
        return p;
    endfunction

    mdu_div_e          state, next_state;
    logic [5:0]        cnt, next_cnt, iters, next_iters;
    logic [31:0]       rem, next_rem, quo, next_quo, dvs, next_dvs;
    logic              neg_q, next_neg_q, neg_r, next_neg_r;
    logic [11:0]       plan;
    logic [31:0]       a_mag, b_mag, step_rem, step_quo;
    logic [32:0]       shifted;
    logic [33:0]       diff;

    // ==========================================================
    // Datapath and sequencing
    always_comb begin
        a_mag      = (is_signed && dividend[31]) ? 32'(-dividend) : dividend;
        b_mag      = (is_signed && divisor[31]) ? 32'(-divisor) : divisor;
        plan       = div_plan(dividend, is_signed);
        shifted    = {rem, quo[31]};
        diff       = {1'b0, shifted} - {2'b00, dvs};
        step_rem   = diff[33] ? shifted[31:0] : diff[31:0];
        step_quo   = {quo[30:0], ~diff[33]};
        quotient   = neg_q ? 32'(-step_quo) : step_quo;
        remainder  = neg_r ? 32'(-step_rem) : step_rem;
        busy       = (state != DIV_IDLE);
        last       = (state == DIV_ITER) && (cnt == 6'h01);
        next_state = state;
        next_cnt   = cnt;
        next_iters = iters;
        next_rem   = rem;
        next_quo   = quo;
        next_dvs   = dvs;
        next_neg_q = neg_q;
        next_neg_r = neg_r;
        case (state)
            DIV_PAD: begin
                next_cnt = 6'(cnt - 6'h01);
                if (cnt == 6'h01) begin
                    next_state = DIV_ITER;
                    next_cnt   = iters;
                end
            end
            DIV_ITER: begin
                next_rem = step_rem;
                next_quo = step_quo;
                next_cnt = 6'(cnt - 6'h01);
                if (cnt == 6'h01) begin
                    next_state = DIV_IDLE;
                end
            end
            default: begin
            end
        endcase
        if (start) begin
            // Skipped high bits are known zero, so the dividend is pre-shifted past them.
            next_quo   = a_mag << (6'(DIV_ITER_FULL) - plan[5:0]);
            next_rem   = '0;
            next_dvs   = b_mag;
            next_neg_q = is_signed && (dividend[31] ^ divisor[31]);
            next_neg_r = is_signed && dividend[31];
            next_iters = plan[5:0];
            next_state = (plan[11:6] != 6'h00) ? DIV_PAD : DIV_ITER;
            next_cnt   = (plan[11:6] != 6'h00) ? plan[11:6] : plan[5:0];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= DIV_IDLE;
            cnt   <= '0;
            iters <= '0;
            rem   <= '0;
            quo   <= '0;
            dvs   <= '0;
            neg_q <= 1'b0;
            neg_r <= 1'b0;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
            iters <= next_iters;
            rem   <= next_rem;
            quo   <= next_quo;
            dvs   <= next_dvs;
            neg_q <= next_neg_q;
            neg_r <= next_neg_r;
        end
    end

    a_div_early_8: assert property (@(posedge clk) disable iff (sys_rst)
        start && (is_signed ? (&dividend[31:7] | ~|dividend[31:7]) : ~|dividend[31:8])
        |-> ##11 last)
        else $error("Narrow divide did not finish on time.");
endmodule

// file: core/mdu_unit.sv
/*
 * Integer execution core with general register file, single-cycle ALU and the
 * multiply/divide unit with its result_high/result_low registers.
 * Assumes the issuing pipeline holds an operation while stall is high.
 */
// Overview of operation
// - Multiply/divide work keeps advancing while the integer pipeline is held.
// - Booth-recoded 32x16 multiplier array feeds separate high and low result registers.
// - Pass count chosen from second operand only: one pass fits 16 bits, else two.
// - Single-pass multiplies issue every cycle; two-pass multiplies every second cycle.
// - Back-to-back 32x32 multiplies raise stall towards issue.
// - Divider produces one quotient bit per clock.
// - Dividend sign extension skips 23, 15 or 7 iterations for 8, 16, 24 bits.
// - Any multiply/divide operation during an active divide stalls until it ends.
// - Multiply latency/repeat: 1/1 or 2/2 to result regs; 2/1 or 3/2 to registers.
// - Divide latency/repeat 12/11, 19/18, 26/25, 33/32 by dividend width.
// - Thirty-two general registers, each 32 bits wide.
// - Register file has two read ports, one write port and full bypassing.
// - Logical, shift, add and subtract complete in one cycle.
// - Leading-zero and leading-one counting implement the count instructions.
module mdu_unit
    import mdu_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              issue_valid,
    input  wire logic [OP_W-1:0]   issue_op,
    input  wire logic [IDX_W-1:0]  first_index,
    input  wire logic [IDX_W-1:0]  second_index,
    input  wire logic [IDX_W-1:0]  dest_index,
    input  wire logic [DATA_W-1:0] immediate,
    input  wire logic              pipeline_hold,
    output logic                   stall,
    output logic [DATA_W-1:0]      result_high,
    output logic [DATA_W-1:0]      result_low,
    output logic                   wb_valid,
    output logic [IDX_W-1:0]       wb_index,
    output logic [DATA_W-1:0]      wb_data
);
    // ==========================================================
    // Helpers
    function automatic logic signed [49:0] booth_32x16(input logic signed [32:0] a,
                                                       input logic [16:0] b);
        logic signed [49:0] acc;
        logic signed [49:0] pp;
        logic [18:0]        bx;
        logic [2:0]         trip;
        acc = '0;
        bx  = {b[16], b, 1'b0};
        for (int i = 0; i < 9; i++) begin
            trip = bx[2*i+2 -: 3];
            case (trip)
                3'b001, 3'b010: pp = 50'(a);
                3'b011:         pp = 50'(a) <<< 1;
                3'b100:         pp = -(50'(a) <<< 1);
                3'b101, 3'b110: pp = -50'(a);
                default:        pp = '0;
            endcase
            acc = acc + (pp <<< (2 * i));
        end
        return acc;
    endfunction

    function automatic logic [5:0] lead_zeros(input logic [31:0] x);
        logic [5:0] n;
        logic       seen;
        n    = '0;
        seen = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            seen = seen | x[i];
            if (!seen) n = 6'(n + 6'h01);
        end
        return n;
    endfunction

    function automatic logic is_mdu(input logic [4:0] op);
        return op[OP_MDU_BIT];
    endfunction

    // ==========================================================
    // General registers
    logic [DATA_W-1:0] gpr [REG_CNT];
    logic              gpr_we;
    logic [IDX_W-1:0]  gpr_widx;
    logic [DATA_W-1:0] gpr_wdata, rd_a, rd_b;
    logic              mwb_pend, next_mwb_pend;
    logic [IDX_W-1:0]  mwb_idx, next_mwb_idx;
    logic [DATA_W-1:0] mwb_data, next_mwb_data;

    // The only write landing in the read cycle is the delayed multiply write, so the bypass
    // taps that register and no combinational loop through the ALU can form.
    always_comb begin
        rd_a = (mwb_pend && mwb_idx == first_index) ? mwb_data : gpr[first_index];
        rd_b = (mwb_pend && mwb_idx == second_index) ? mwb_data : gpr[second_index];
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < REG_CNT; i++) gpr[i] <= '0;
        end else if (gpr_we) begin
            gpr[gpr_widx] <= gpr_wdata;
        end
    end

    // ==========================================================
    // Issue, ALU and multiply/divide control
    mdu_mul_e          mul_st, next_mul_st;
    logic [32:0]       m_a, next_m_a;
    logic [16:0]       m_b, next_m_b;
    logic [49:0]       m_part, next_m_part;
    logic [4:0]        m_op, next_m_op;
    logic [IDX_W-1:0]  m_dst, next_m_dst;
    logic [31:0]       hi, next_hi, lo, next_lo;
    logic              next_wb_valid;
    logic [IDX_W-1:0]  next_wb_index;
    logic [DATA_W-1:0] next_wb_data;
    logic              take, sgn, one_pass, fin, alu_wr, div_start;
    logic              div_busy, div_last;
    logic [31:0]       div_q, div_r, alu_res;
    logic [63:0]       hilo_now, full, mul_fin;
    logic [32:0]       mul_a;
    logic [16:0]       mul_b;
    logic signed [49:0] prod;
    logic [4:0]        fop;

    always_comb begin
        // The divider keeps running whatever the hold input does.
        hilo_now = div_last ? {div_r, div_q} : {hi, lo};
        sgn      = ~issue_op[0];
        one_pass = sgn ? (&rd_b[31:15] | ~|rd_b[31:15]) : ~|rd_b[31:16];
        stall    = issue_valid && ((is_mdu(issue_op) && mul_st == MUL_PASS2)
                 || (is_mdu(issue_op) && div_busy && !div_last)
                 || (!is_mdu(issue_op) && issue_op != OP_NOP && mwb_pend)
                 || ((issue_op == OP_MFHI || issue_op == OP_MFLO) && mwb_pend));
        take      = issue_valid && !pipeline_hold && !stall;
        div_start = take && (issue_op == OP_DIV || issue_op == OP_DIVU);
        case (issue_op)
            OP_AND:      alu_res = rd_a & rd_b;
            OP_OR:       alu_res = rd_a | rd_b;
            OP_XOR:      alu_res = rd_a ^ rd_b;
            OP_ADD:      alu_res = 32'(rd_a + rd_b);
            OP_SUB:      alu_res = 32'(rd_a - rd_b);
            OP_SLL:      alu_res = rd_a << rd_b[4:0];
            OP_SRL:      alu_res = rd_a >> rd_b[4:0];
            OP_SRA:      alu_res = 32'($signed(rd_a) >>> rd_b[4:0]);
            OP_CLZ:      alu_res = 32'(lead_zeros(rd_a));
            OP_CLO:      alu_res = 32'(lead_zeros(~rd_a));
            OP_LOAD_IMM: alu_res = immediate;
            OP_MFHI:     alu_res = hilo_now[63:32];
            OP_MFLO:     alu_res = hilo_now[31:0];
            default:     alu_res = '0;
        endcase
        alu_wr = take && (issue_op inside {[OP_AND:OP_LOAD_IMM], OP_MFHI, OP_MFLO});
        // One shared array: the second pass reuses it with the stored upper half.
        if (mul_st == MUL_PASS2) begin
            mul_a = m_a;
            mul_b = m_b;
        end else begin
            mul_a = sgn ? {rd_a[31], rd_a} : {1'b0, rd_a};
            mul_b = one_pass ? rd_b[16:0] : {1'b0, rd_b[15:0]};
        end
        prod    = booth_32x16(mul_a, mul_b);
        full    = (mul_st == MUL_PASS2) ? 64'({{14{m_part[49]}}, m_part} + ({{14{prod[49]}}, prod} << 16))
                                        : {{14{prod[49]}}, prod};
        fop     = (mul_st == MUL_PASS2) ? m_op : issue_op;
        fin     = (mul_st == MUL_PASS2)
               || (take && issue_op inside {[OP_MULT:OP_MUL]} && one_pass);
        mul_fin = full;
        next_mul_st   = MUL_IDLE;
        next_m_a      = m_a;
        next_m_b      = m_b;
        next_m_part   = m_part;
        next_m_op     = m_op;
        next_m_dst    = m_dst;
        next_hi       = hilo_now[63:32];
        next_lo       = hilo_now[31:0];
        next_mwb_pend = 1'b0;
        next_mwb_idx  = mwb_idx;
        next_mwb_data = mwb_data;
        if (take && issue_op inside {[OP_MULT:OP_MUL]} && !one_pass) begin
            next_mul_st = MUL_PASS2;
            next_m_a    = mul_a;
            next_m_b    = sgn ? {rd_b[31], rd_b[31:16]} : {1'b0, rd_b[31:16]};
            next_m_part = prod;
            next_m_op   = issue_op;
            next_m_dst  = dest_index;
        end
        if (fin) begin
            case (fop)
                OP_MADD, OP_MADDU: {next_hi, next_lo} = 64'(hilo_now + mul_fin);
                OP_MSUB, OP_MSUBU: {next_hi, next_lo} = 64'(hilo_now - mul_fin);
                OP_MUL: begin
                    // Result to a register takes one extra write cycle.
                    next_mwb_pend = 1'b1;
                    next_mwb_idx  = (mul_st == MUL_PASS2) ? m_dst : dest_index;
                    next_mwb_data = mul_fin[31:0];
                end
                default: {next_hi, next_lo} = mul_fin;
            endcase
        end
        gpr_we        = alu_wr || mwb_pend;
        gpr_widx      = mwb_pend ? mwb_idx : dest_index;
        gpr_wdata     = mwb_pend ? mwb_data : alu_res;
        next_wb_valid = gpr_we;
        next_wb_index = gpr_widx;
        next_wb_data  = gpr_wdata;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mul_st    <= MUL_IDLE;
            m_a       <= '0;
            m_b       <= '0;
            m_part    <= '0;
            m_op      <= OP_NOP;
            m_dst     <= '0;
            hi        <= '0;
            lo        <= '0;
            mwb_pend  <= 1'b0;
            mwb_idx   <= '0;
            mwb_data  <= '0;
            wb_valid  <= 1'b0;
            wb_index  <= '0;
            wb_data   <= '0;
        end else begin
            mul_st    <= next_mul_st;
            m_a       <= next_m_a;
            m_b       <= next_m_b;
            m_part    <= next_m_part;
            m_op      <= next_m_op;
            m_dst     <= next_m_dst;
            hi        <= next_hi;
            lo        <= next_lo;
            mwb_pend  <= next_mwb_pend;
            mwb_idx   <= next_mwb_idx;
            mwb_data  <= next_mwb_data;
            wb_valid  <= next_wb_valid;
            wb_index  <= next_wb_index;
            wb_data   <= next_wb_data;
        end
    end

    assign result_high = hi;
    assign result_low  = lo;

    mdu_divider u_div (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .start     (div_start),
        .is_signed (~issue_op[0]),
        .dividend  (rd_a),
        .divisor   (rd_b),
        .busy      (div_busy),
        .last      (div_last),
        .quotient  (div_q),
        .remainder (div_r)
    );

    // ==========================================================
    // Checks
    a_back_to_back: assert property (@(posedge clk) disable iff (sys_rst)
        mul_st == MUL_PASS2 && issue_valid && is_mdu(issue_op) |-> stall)
        else $error("Second pass did not block issue.");
    a_single_rate: assert property (@(posedge clk) disable iff (sys_rst)
        issue_valid && issue_op == OP_MULT && mul_st == MUL_IDLE && !div_busy |-> !stall)
        else $error("Single-pass multiply was refused.");
    a_two_pass_seq: assert property (@(posedge clk) disable iff (sys_rst)
        take && issue_op == OP_MULT && !one_pass |=> mul_st == MUL_PASS2 ##1 mul_st == MUL_IDLE)
        else $error("Two-pass multiply sequence wrong.");
    a_div_interlock: assert property (@(posedge clk) disable iff (sys_rst)
        div_busy && !div_last && issue_valid && is_mdu(issue_op) |-> stall)
        else $error("Issue during divide not stalled.");
    a_div_full_time: assert property (@(posedge clk) disable iff (sys_rst)
        div_start && (issue_op[0] ? |rd_a[31:24] : !(&rd_a[31:23] | ~|rd_a[31:23]))
        |-> ##32 div_last ##1 !div_busy)
        else $error("Wide divide latency wrong.");
    a_runs_on_hold: assert property (@(posedge clk) disable iff (sys_rst)
        div_busy && !div_last && pipeline_hold |=> div_busy && $changed(u_div.cnt))
        else $error("Divider paused during hold.");
    a_alu_one_cycle: assert property (@(posedge clk) disable iff (sys_rst)
        take && issue_op == OP_ADD |=> wb_valid && wb_data == 32'($past(rd_a) + $past(rd_b)))
        else $error("Add result not written next cycle.");
    a_mult_latency: assert property (@(posedge clk) disable iff (sys_rst)
        take && issue_op == OP_MULTU && one_pass
        |=> {hi, lo} == 64'({32'h0, $past(rd_a)} * {48'h0, $past(rd_b[15:0])}))
        else $error("Short multiply result late or wrong.");
    a_mul_reg_late: assert property (@(posedge clk) disable iff (sys_rst)
        take && issue_op == OP_MUL && !one_pass |-> ##3 wb_valid && wb_index == $past(dest_index, 3))
        else $error("Long register multiply write timing wrong.");
endmodule

// file: bench/mdu_issuer.sv
/*
 * Issuing pipeline model that offers one operation at a time to the unit.
 * Assumes the bench calls send just after a rising edge of the shared clock.
 */
module mdu_issuer
    import mdu_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              stall,
    input  wire logic              pipeline_hold,
    output logic                   issue_valid,
    output logic [OP_W-1:0]        issue_op,
    output logic [IDX_W-1:0]       first_index,
    output logic [IDX_W-1:0]       second_index,
    output logic [IDX_W-1:0]       dest_index,
    output logic [DATA_W-1:0]      immediate
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        issue_valid = 1'b0;
        issue_op = OP_NOP;
        {first_index, second_index, dest_index} = 15'h0000;
        immediate = 32'h0000_0000;
    end

    // ==========================================================
    // Offer
    // Stall is sampled at the falling edge, where it has settled.
    task automatic send(input logic [4:0] op, a, b, d, input logic [31:0] imm,
                        output int stalls);
        logic s;
        stalls = 0;
        issue_valid = 1'b1;
        issue_op = op;
        first_index = a;
        second_index = b;
        dest_index = d;
        immediate = imm;
        forever begin
            @(negedge clk);
            s = stall | pipeline_hold;
            if (stall) stalls++;
            @(posedge clk);
            if (!s) break;
        end
        #1;
    endtask

    // Back-to-back offers keep valid high; the bench releases only before it lets an edge pass.
    task automatic idle;
        issue_valid = 1'b0;
        issue_op = OP_NOP;
        // Released operands show the inverse so stale values are never trusted.
        first_index = ~first_index;
        second_index = ~second_index;
        immediate = ~immediate;
    endtask
endmodule

// file: bench/testbench.sv
/*
 * Self-checking bench for the multiply/divide unit and its integer core.
 * Assumes the issuer model drives the issue port and the bench drives reset and hold.
 */
module testbench;
    import mdu_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic              clk, sys_rst, pipeline_hold, issue_valid, stall, wb_valid;
    logic [OP_W-1:0]   issue_op;
    logic [IDX_W-1:0]  first_index, second_index, dest_index, wb_index;
    logic [DATA_W-1:0] immediate, result_high, result_low, wb_data;
    int                error_cnt = 0, samples_checked = 0, cyc = 0, s;

    mdu_unit dut (.clk, .sys_rst, .issue_valid, .issue_op, .first_index, .second_index,
        .dest_index, .immediate, .pipeline_hold, .stall, .result_high, .result_low,
        .wb_valid, .wb_index, .wb_data);
    mdu_issuer issuer (.clk, .stall, .pipeline_hold, .issue_valid, .issue_op,
        .first_index, .second_index, .dest_index, .immediate);

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ==========================================================
    // Helpers
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic op(input logic [4:0] o, a, b, d, input logic [31:0] imm = 32'h0);
        issuer.send(o, a, b, d, imm, s);
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_alu;
        op(OP_LOAD_IMM, 5'h00, 5'h00, 5'h01, 32'h0001_0000);
        op(OP_LOAD_IMM, 5'h00, 5'h00, 5'h02, 32'h0000_0003);
        op(OP_LOAD_IMM, 5'h00, 5'h00, 5'h04, 32'h0000_00C8);
        op(OP_LOAD_IMM, 5'h00, 5'h00, 5'h05, 32'h0000_0007);
        op(OP_ADD, 5'h01, 5'h02, 5'h06);
        chk("wb_valid", {31'h0, wb_valid}, 32'h1);
        chk("wb_index", {27'h0, wb_index}, 32'h6);
        chk("add", wb_data, 32'h0001_0003);
        op(OP_CLZ, 5'h06, 5'h00, 5'h07);
        chk("clz", wb_data, 32'h0000_000F);
        $display("test alu done");
    endtask

    task automatic t_mul;
        op(OP_MULTU, 5'h02, 5'h01, 5'h00);
        chk("lo early", result_low, 32'h0);
        issuer.idle;
        @(posedge clk);
        #1;
        chk("lo long", result_low, 32'h0003_0000);
        chk("hi long", result_high, 32'h0);
        op(OP_MULT, 5'h02, 5'h01, 5'h00);
        op(OP_MULT, 5'h02, 5'h02, 5'h00);
        chk("long stall", s, 32'h1);
        chk("lo short", result_low, 32'h9);
        op(OP_MADDU, 5'h02, 5'h02, 5'h00);
        chk("madd stall", s, 32'h0);
        chk("lo madd", result_low, 32'h12);
        $display("test mul done");
    endtask

    // Hold the pipeline for four cycles; the divide must keep counting meanwhile.
    task automatic t_div;
        op(OP_DIVU, 5'h04, 5'h05, 5'h00);
        issuer.idle;
        pipeline_hold = 1'b1;
        repeat (4) @(posedge clk);
        #1 pipeline_hold = 1'b0;
        chk("lo before", result_low, 32'h12);
        op(OP_MFLO, 5'h00, 5'h00, 5'h08);
        chk("div stall", s, 32'h6);
        chk("quotient", wb_data, 32'h1C);
        chk("lo at 12", result_low, 32'h1C);
        issuer.idle;
        @(posedge clk);
        #1;
        chk("lo div", result_low, 32'h1C);
        chk("hi div", result_high, 32'h4);
        $display("test div done");
    endtask

    // Signed paths: subtract, shift, leading ones, long register multiply and a full divide.
    task automatic t_mix;
        op(OP_SUB, 5'h02, 5'h04, 5'h09);
        chk("sub", wb_data, 32'hFFFF_FF3B);
        op(OP_SRA, 5'h09, 5'h02, 5'h0A);
        chk("sra", wb_data, 32'hFFFF_FFE7);
        op(OP_CLO, 5'h0A, 5'h00, 5'h0B);
        chk("clo", wb_data, 32'h0000_001B);
        op(OP_MUL, 5'h09, 5'h01, 5'h0C);
        issuer.idle;
        @(posedge clk);
        #1 chk("mul early", {31'h0, wb_valid}, 32'h0);
        @(posedge clk);
        #1 chk("mul index", {27'h0, wb_index}, 32'hC);
        chk("mul", wb_data, 32'hFF3B_0000);
        op(OP_MULTU, 5'h02, 5'h05, 5'h00);
        chk("lo multu", result_low, 32'h15);
        op(OP_MSUB, 5'h02, 5'h02, 5'h00);
        chk("lo msub", result_low, 32'h0C);
        chk("hi msub", result_high, 32'h0);
        op(OP_DIV, 5'h0C, 5'h04, 5'h00);
        op(OP_MFHI, 5'h00, 5'h00, 5'h0E);
        chk("div repeat", s, 32'h1F);
        chk("remainder", wb_data, 32'hFFFF_FF40);
        chk("lo signed div", result_low, 32'hFFFF_03D8);
        $display("test mix done");
    endtask

    initial begin
        sys_rst = 1'b1;
        pipeline_hold = 1'b0;
        repeat (5) @(posedge clk);
        #1 sys_rst = 1'b0;
        @(posedge clk);
        #1;
        t_alu;
        t_mul;
        t_div;
        t_mix;
        final_report;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            final_report;
        end
    end
endmodule
